// ==== inc/mfio_pkg.sv ====
/*
 * mfio_pkg: register map, field layout, reset values and timing constants
 * of the multifunction i/o slot block.
 * assumes: one 50 MHz core clock; 32-bit register port with byte offsets.
 */
package mfio_pkg;
    // clock
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_NS = 20;
    // supervision and filter times in their own units
    localparam int unsigned WDOG_MS = 100;
    localparam int unsigned FILT_DEF_US = 3000;
    localparam int unsigned FILT_MIN_US = 10;
    localparam longint unsigned WDOG_CYC = longint'(WDOG_MS) * 1_000_000 / CLK_NS;
    localparam int unsigned FILT_DEF_CYC = FILT_DEF_US * 1000 / CLK_NS;
    localparam int unsigned FILT_MIN_CYC = (FILT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FILT_W = 24;
    localparam int unsigned WDOG_W = 32;
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OUT = 8'h04;
    localparam logic [7:0] REG_FILT = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_COUNT = 8'h10;
    localparam logic [7:0] REG_LATCH = 8'h14;
    localparam logic [7:0] REG_THR_ON = 8'h18;
    localparam logic [7:0] REG_THR_OFF = 8'h1C;
    localparam logic [7:0] REG_PWM_PER = 8'h20;
    localparam logic [7:0] REG_PWM_DUTY = 8'h24;
    localparam logic [7:0] REG_ANALOG = 8'h28;
    localparam logic [7:0] REG_IRQ_STAT = 8'h2C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h30;
    // control field positions
    localparam int unsigned CTRL_S1_LSB = 0;
    localparam int unsigned CTRL_S2_LSB = 2;
    localparam int unsigned CTRL_S3_BIT = 4;
    localparam int unsigned CTRL_S4_LSB = 5;
    localparam int unsigned CTRL_ZERO_BIT = 7;
    localparam int unsigned CTRL_W = 8;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // status / irq layout
    localparam int unsigned STAT_WDOG_BIT = 8;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_WDOG = 0;
    localparam int unsigned IRQ_LATCH = 1;
    localparam int unsigned IRQ_THR = 2;
    localparam int unsigned IRQ_INCHG = 3;
    // analog and pwm fields
    localparam int unsigned ADC_W = 12;
    localparam int unsigned ANA_HI_LSB = 16;
    localparam int unsigned PWM_W = 16;
    localparam logic [15:0] PWM_FULL = 16'hFFFF;
    localparam logic [15:0] PWM_PER_RST = 16'hFFFF;
    // slot module selections
    typedef enum logic [1:0] {MFIO_S1_NONE, MFIO_S1_DIO, MFIO_S1_CNT, MFIO_S1_ENC} mfio_s1_t;
    typedef enum logic [1:0] {MFIO_S2_NONE, MFIO_S2_DIO, MFIO_S2_PWM, MFIO_S2_RSV} mfio_s2_t;
    typedef enum logic [1:0] {MFIO_S4_NONE, MFIO_S4_DI, MFIO_S4_ANA, MFIO_S4_RSV} mfio_s4_t;
endpackage : mfio_pkg

// ==== design/mfio_filter.sv ====
/*
 * mfio_filter: one digital input debounce filter.
 * assumes: din already synchronised to clk; limit >= 1 cycle, held steady.
 */
`timescale 1ns/1ps
module mfio_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    input wire logic [mfio_pkg::FILT_W-1:0] limit,
    output logic q_r
);
    logic [mfio_pkg::FILT_W-1:0] cnt_r;
    logic [mfio_pkg::FILT_W-1:0] cnt_nxt;
    logic q_nxt;
    logic differs;

    // new level accepted only after limit stable cycles
    // compare with >= so a limit lowered mid-count cannot strand the counter past it
    assign differs = din != q_r;
    assign cnt_nxt = (!differs || cnt_r >= limit - 1'b1) ? '0 : cnt_r + 1'b1;
    assign q_nxt = (differs && cnt_r >= limit - 1'b1) ? din : q_r;

    // state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            q_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            q_r <= q_nxt;
        end
    end
endmodule : mfio_filter

// ==== design/mfio_top.sv ====
/*
 * mfio_top: four-slot multifunction i/o block with eight filtered inputs,
 * four outputs, counter/encoder, pwm, analog capture, watchdog and irq.
 * assumes: field inputs asynchronous to core_clk; analog samples come from
 * an external 12-bit converter on core_clk; host drives the register port.
 */
`timescale 1ns/1ps
// Functional notes
// - each slot holds at most one module, which sets its i/o mode; may be empty
// - host communication supervised by a fixed 100 ms watchdog
// - slot one owns in1, in2, in3 in encoder mode, out1, out2
// - encoder mode: two track inputs up to 250 kHz, two encoder outputs
// - counter mode: count input, direction input, two counter outputs
// - in3 high in encoder mode latches the value or resets the counter
// - slot two owns in3, in4, out3, out4; dual i/o or pwm module
// - pwm module keeps two filtered inputs, drives both outputs as pwm
// - slot three: in5, in6 as fixed filtered inputs only
// - slot four: two 12-bit analog inputs or two filtered digital inputs
// - all inputs filtered; default 3 ms, minimum 10 us (counter and encoder count in1, in2 from the unfiltered synchronised tracks)
// - only inputs three to six take a configurable filter time
// - one indicator per input follows its filtered state
module mfio_top #(
    parameter longint unsigned WDOG_CYCLES = mfio_pkg::WDOG_CYC,
    parameter int unsigned FILT_DEF_CYCLES = mfio_pkg::FILT_DEF_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] field_in,
    input wire logic [mfio_pkg::ADC_W-1:0] adc_ch7,
    input wire logic [mfio_pkg::ADC_W-1:0] adc_ch8,
    input wire logic adc_valid,
    output logic [3:0] field_out,
    output logic [7:0] in_led,
    output logic wdog_err,
    output logic irq
);
    localparam logic [mfio_pkg::FILT_W-1:0] FILT_DEF = mfio_pkg::FILT_W'(FILT_DEF_CYCLES);
    localparam logic [mfio_pkg::FILT_W-1:0] FILT_MIN = mfio_pkg::FILT_W'(mfio_pkg::FILT_MIN_CYC);
    localparam logic [mfio_pkg::WDOG_W-1:0] WDOG_LAST = mfio_pkg::WDOG_W'(WDOG_CYCLES - 1);

    // pwm level: full-scale duty keeps the stage on for the whole period
    function automatic logic pwm_level(input logic [15:0] cnt, input logic [15:0] duty);
        pwm_level = (duty == mfio_pkg::PWM_FULL) || (cnt < duty);
    endfunction : pwm_level

    // reset release and input synchronisers
    logic [1:0] rst_sync_r;
    logic rst_n_s;
    logic [7:0] in_meta_r;
    logic [7:0] in_sync_r;

    // registers
    logic [mfio_pkg::CTRL_W-1:0] ctrl_r;
    logic [3:0] out_sw_r;
    logic [mfio_pkg::FILT_W-1:0] filt_cfg_r;
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic [31:0] latch_r;
    logic [31:0] thr_on_r;
    logic [31:0] thr_off_r;
    logic [15:0] pwm_per_r;
    logic [15:0] pwm_duty3_r;
    logic [15:0] pwm_duty4_r;
    logic [15:0] pwm_cnt_r;
    logic [mfio_pkg::ADC_W-1:0] ana7_r;
    logic [mfio_pkg::ADC_W-1:0] ana8_r;
    logic [mfio_pkg::IRQ_W-1:0] irq_stat_r;
    logic [mfio_pkg::IRQ_W-1:0] irq_mask_r;
    logic [mfio_pkg::IRQ_W-1:0] irq_evt;
    logic [31:0] reg_rdata_r;
    logic [31:0] rd_mux;
    logic [mfio_pkg::WDOG_W-1:0] wdog_cnt_r;
    logic wdog_err_r;
    logic wdog_expire;
    logic [7:0] filt_q;
    logic [7:0] filt_prev_r;
    logic [3:0] out_r;
    logic [3:0] out_nxt;
    logic thr_out_r;
    logic thr_out_nxt;
    logic enc_a_r;
    logic enc_b_r;
    logic in3_prev_r;

    // decoded slot modes
    mfio_pkg::mfio_s1_t s1_mode;
    mfio_pkg::mfio_s2_t s2_mode;
    mfio_pkg::mfio_s4_t s4_mode;
    logic s3_on;
    logic enc_mode;
    logic cnt_mode;
    logic pwm_mode;
    logic zero_on_in3;

    // one field per slot can only hold one module code at a time
    assign s1_mode = mfio_pkg::mfio_s1_t'(ctrl_r[mfio_pkg::CTRL_S1_LSB +: 2]);
    assign s2_mode = mfio_pkg::mfio_s2_t'(ctrl_r[mfio_pkg::CTRL_S2_LSB +: 2]);
    assign s3_on = ctrl_r[mfio_pkg::CTRL_S3_BIT];
    assign s4_mode = mfio_pkg::mfio_s4_t'(ctrl_r[mfio_pkg::CTRL_S4_LSB +: 2]);
    assign zero_on_in3 = ctrl_r[mfio_pkg::CTRL_ZERO_BIT];
    assign enc_mode = s1_mode == mfio_pkg::MFIO_S1_ENC;
    assign cnt_mode = s1_mode == mfio_pkg::MFIO_S1_CNT;
    assign pwm_mode = s2_mode == mfio_pkg::MFIO_S2_PWM;

    // register write decode
    logic wr_ctrl, wr_out, wr_filt, wr_count, wr_thr_on, wr_thr_off;
    logic wr_per, wr_duty, wr_istat, wr_imask;
    assign wr_ctrl = reg_wr && reg_addr == mfio_pkg::REG_CTRL;
    assign wr_out = reg_wr && reg_addr == mfio_pkg::REG_OUT;
    assign wr_filt = reg_wr && reg_addr == mfio_pkg::REG_FILT;
    assign wr_count = reg_wr && reg_addr == mfio_pkg::REG_COUNT;
    assign wr_thr_on = reg_wr && reg_addr == mfio_pkg::REG_THR_ON;
    assign wr_thr_off = reg_wr && reg_addr == mfio_pkg::REG_THR_OFF;
    assign wr_per = reg_wr && reg_addr == mfio_pkg::REG_PWM_PER;
    assign wr_duty = reg_wr && reg_addr == mfio_pkg::REG_PWM_DUTY;
    assign wr_istat = reg_wr && reg_addr == mfio_pkg::REG_IRQ_STAT;
    assign wr_imask = reg_wr && reg_addr == mfio_pkg::REG_IRQ_MASK;

    // reset release: async assert, two-stage deassert
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_r[1];

    // field pins are asynchronous: two flops before any logic
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            in_meta_r <= '0;
            in_sync_r <= '0;
        end else begin
            in_meta_r <= field_in;
            in_sync_r <= in_meta_r;
        end
    end

    // filters: inputs 3..6 use the programmable time, others fixed default
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_filt
            localparam bit CFG = (gi >= 2) && (gi <= 5);
            mfio_filter u_filt (
                .clk(core_clk),
                .rst_n(rst_n_s),
                .din(in_sync_r[gi]),
                .limit(CFG ? filt_cfg_r : FILT_DEF),
                .q_r(filt_q[gi])
            );
        end
    endgenerate
    // indicators mirror filtered state; in3 belongs to slot one in encoder mode
    assign in_led = filt_q;

    // watchdog: any register write is a host refresh
    assign wdog_expire = !wdog_err_r && wdog_cnt_r == WDOG_LAST;
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wdog_cnt_r <= '0;
            wdog_err_r <= 1'b0;
        end else if (reg_wr) begin
            wdog_cnt_r <= '0;
            wdog_err_r <= 1'b0;
        end else if (wdog_expire) begin
            wdog_err_r <= 1'b1;
        end else if (!wdog_err_r) begin
            wdog_cnt_r <= wdog_cnt_r + 1'b1;
        end
    end
    assign wdog_err = wdog_err_r;

    // encoder x4 quadrature and pulse counter on the fast synchronised tracks
    // filter is bypassed here: a 3 ms debounce would swallow 250 kHz edges
    logic enc_step, enc_up, cnt_edge, in3_hit;
    assign enc_step = (in_sync_r[0] ^ enc_a_r) ^ (in_sync_r[1] ^ enc_b_r);
    assign enc_up = enc_a_r ^ in_sync_r[1];
    assign cnt_edge = in_sync_r[0] && !enc_a_r;
    assign in3_hit = enc_mode && filt_q[2] && !in3_prev_r;

    // next count value
    always_comb begin
        count_nxt = count_r;
        if (wr_count) begin
            count_nxt = reg_wdata;
        end else if (in3_hit && zero_on_in3) begin
            count_nxt = '0;
        end else if (enc_mode && enc_step) begin
            count_nxt = enc_up ? count_r + 1'b1 : count_r - 1'b1;
        end else if (cnt_mode && cnt_edge) begin
            // direction input high counts up, low counts down
            count_nxt = in_sync_r[1] ? count_r + 1'b1 : count_r - 1'b1;
        end
    end

    // out1 switches on at the on threshold, off at the off threshold
    assign thr_out_nxt = (count_nxt == thr_on_r) ? 1'b1 :
                         (count_nxt == thr_off_r) ? 1'b0 : thr_out_r;

    // slot output map; watchdog expiry forces every output inactive
    always_comb begin
        out_nxt = '0;
        if (!wdog_err_r) begin
            case (s1_mode)
                mfio_pkg::MFIO_S1_DIO: out_nxt[1:0] = out_sw_r[1:0];
                mfio_pkg::MFIO_S1_CNT,
                mfio_pkg::MFIO_S1_ENC: out_nxt[1:0] = {out_sw_r[1], thr_out_r};
                default: out_nxt[1:0] = 2'b00;
            endcase
            case (s2_mode)
                mfio_pkg::MFIO_S2_DIO: out_nxt[3:2] = out_sw_r[3:2];
                mfio_pkg::MFIO_S2_PWM: out_nxt[3:2] = {pwm_level(pwm_cnt_r, pwm_duty4_r),
                                                      pwm_level(pwm_cnt_r, pwm_duty3_r)};
                default: out_nxt[3:2] = 2'b00;
            endcase
        end
    end
    assign field_out = out_r;

    // interrupt events
    assign irq_evt[mfio_pkg::IRQ_WDOG] = wdog_expire;
    assign irq_evt[mfio_pkg::IRQ_LATCH] = in3_hit;
    assign irq_evt[mfio_pkg::IRQ_THR] = thr_out_nxt && !thr_out_r && (enc_mode || cnt_mode);
    assign irq_evt[mfio_pkg::IRQ_INCHG] = filt_q != filt_prev_r;
    assign irq = |(irq_stat_r & irq_mask_r);

    // control/config registers written by software
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl_r <= mfio_pkg::CTRL_RST;
            out_sw_r <= '0;
            filt_cfg_r <= FILT_DEF;
            thr_on_r <= '0;
            thr_off_r <= '0;
            pwm_per_r <= mfio_pkg::PWM_PER_RST;
            pwm_duty3_r <= '0;
            pwm_duty4_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr_ctrl) ctrl_r <= reg_wdata[mfio_pkg::CTRL_W-1:0];
            if (wr_out) out_sw_r <= reg_wdata[3:0];
            // shorter settings are clamped to the 10 us floor
            if (wr_filt) filt_cfg_r <= (reg_wdata[mfio_pkg::FILT_W-1:0] < FILT_MIN) ?
                                       FILT_MIN : reg_wdata[mfio_pkg::FILT_W-1:0];
            if (wr_thr_on) thr_on_r <= reg_wdata;
            if (wr_thr_off) thr_off_r <= reg_wdata;
            if (wr_per) pwm_per_r <= reg_wdata[mfio_pkg::PWM_W-1:0];
            if (wr_duty) pwm_duty3_r <= reg_wdata[mfio_pkg::PWM_W-1:0];
            if (wr_duty) pwm_duty4_r <= reg_wdata[mfio_pkg::ANA_HI_LSB +: mfio_pkg::PWM_W];
            if (wr_imask) irq_mask_r <= reg_wdata[mfio_pkg::IRQ_W-1:0];
        end
    end

    // block state: counter, latch, pwm timebase, analog, outputs
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            count_r <= '0;
            latch_r <= '0;
            enc_a_r <= 1'b0;
            enc_b_r <= 1'b0;
            in3_prev_r <= 1'b0;
            thr_out_r <= 1'b0;
            pwm_cnt_r <= '0;
            ana7_r <= '0;
            ana8_r <= '0;
            out_r <= '0;
            filt_prev_r <= '0;
        end else begin
            count_r <= count_nxt;
            enc_a_r <= in_sync_r[0];
            enc_b_r <= in_sync_r[1];
            in3_prev_r <= filt_q[2];
            thr_out_r <= thr_out_nxt;
            out_r <= out_nxt;
            filt_prev_r <= filt_q;
            if (in3_hit && !zero_on_in3) latch_r <= count_r;
            // timebase wraps at the programmed period
            pwm_cnt_r <= (!pwm_mode || pwm_cnt_r >= pwm_per_r) ? '0 : pwm_cnt_r + 1'b1;
            if (adc_valid && s4_mode == mfio_pkg::MFIO_S4_ANA) begin
                ana7_r <= adc_ch7;
                ana8_r <= adc_ch8;
            end
        end
    end

    // sticky status: a new event wins over a same-cycle clear
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_istat ? reg_wdata[mfio_pkg::IRQ_W-1:0] : '0))
                          | irq_evt;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        if (reg_addr == mfio_pkg::REG_CTRL) begin
            rd_mux[mfio_pkg::CTRL_W-1:0] = ctrl_r;
        end else if (reg_addr == mfio_pkg::REG_OUT) begin
            rd_mux[3:0] = out_sw_r;
        end else if (reg_addr == mfio_pkg::REG_FILT) begin
            rd_mux[mfio_pkg::FILT_W-1:0] = filt_cfg_r;
        end else if (reg_addr == mfio_pkg::REG_STATUS) begin
            rd_mux[7:0] = filt_q;
            rd_mux[mfio_pkg::STAT_WDOG_BIT] = wdog_err_r;
            rd_mux[mfio_pkg::ANA_HI_LSB +: 4] = out_r;
        end else if (reg_addr == mfio_pkg::REG_COUNT) begin
            rd_mux = count_r;
        end else if (reg_addr == mfio_pkg::REG_LATCH) begin
            rd_mux = latch_r;
        end else if (reg_addr == mfio_pkg::REG_THR_ON) begin
            rd_mux = thr_on_r;
        end else if (reg_addr == mfio_pkg::REG_THR_OFF) begin
            rd_mux = thr_off_r;
        end else if (reg_addr == mfio_pkg::REG_PWM_PER) begin
            rd_mux[mfio_pkg::PWM_W-1:0] = pwm_per_r;
        end else if (reg_addr == mfio_pkg::REG_PWM_DUTY) begin
            rd_mux = {pwm_duty4_r, pwm_duty3_r};
        end else if (reg_addr == mfio_pkg::REG_ANALOG) begin
            rd_mux[mfio_pkg::ADC_W-1:0] = ana7_r;
            rd_mux[mfio_pkg::ANA_HI_LSB +: mfio_pkg::ADC_W] = ana8_r;
        end else if (reg_addr == mfio_pkg::REG_IRQ_STAT) begin
            rd_mux[mfio_pkg::IRQ_W-1:0] = irq_stat_r;
        end else if (reg_addr == mfio_pkg::REG_IRQ_MASK) begin
            rd_mux[mfio_pkg::IRQ_W-1:0] = irq_mask_r;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            reg_rdata_r <= '0;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : '0;
        end
    end
    assign reg_rdata = reg_rdata_r;
endmodule : mfio_top

// ==== verif/mfio_top_sva.sv ====
/* mfio_top_sva: port-level checks of the slot block.
   assumes: bound to mfio_top; inputs 1 and 8 keep the default filter. */
`timescale 1ns/1ps
module mfio_top_sva #(
    parameter longint unsigned WDOG_CYCLES = 200,
    parameter int unsigned FILT_DEF_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] field_in,
    input wire logic [mfio_pkg::ADC_W-1:0] adc_ch7,
    input wire logic [mfio_pkg::ADC_W-1:0] adc_ch8,
    input wire logic adc_valid,
    input wire logic [3:0] field_out,
    input wire logic [7:0] in_led,
    input wire logic wdog_err,
    input wire logic irq
);
    logic [31:0] idle_r;
    logic [9:0] st0_r;
    logic [9:0] st7_r;
    // cycles since last host write, and pin stable counts (saturating)
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_r <= '0;
            st0_r <= '0;
            st7_r <= '0;
        end else begin
            idle_r <= reg_wr ? '0 : idle_r + 32'h0000_0001;
            st0_r <= $changed(field_in[0]) ? '0 : st0_r + {9'h000, st0_r != 10'h3ff};
            st7_r <= $changed(field_in[7]) ? '0 : st7_r + {9'h000, st7_r != 10'h3ff};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    chk_wdog_force: assert property (wdog_err && $past(wdog_err) |-> field_out == 4'h0)
        else $error("outputs active while watchdog expired");
    chk_wdog_hold: assert property (wdog_err && !reg_wr |=> wdog_err)
        else $error("watchdog error dropped without host write");
    chk_wdog_clear: assert property (reg_wr |-> ##[1:2] !wdog_err)
        else $error("host write did not clear watchdog error");
    chk_wdog_early: assert property (idle_r < WDOG_CYCLES - 2 |-> !$rose(wdog_err))
        else $error("watchdog expired too early");
    chk_wdog_late: assert property (idle_r == WDOG_CYCLES + 6 |-> wdog_err)
        else $error("watchdog failed to expire");
    // pin reaches the filter three cycles late, so judge stability as it was then
    chk_filt_in1: assert property ($changed(in_led[0]) |->
        $past(st0_r, 3) >= FILT_DEF_CYCLES - 2)
        else $error("input 1 accepted before filter time");
    chk_filt_in8: assert property ($changed(in_led[7]) |->
        $past(st7_r, 3) >= FILT_DEF_CYCLES - 2)
        else $error("input 8 not on default filter");
    chk_led_follow: assert property (st0_r == FILT_DEF_CYCLES + 6 |-> in_led[0] == field_in[0])
        else $error("indicator 1 does not follow input");
endmodule : mfio_top_sva

bind mfio_top mfio_top_sva #(.WDOG_CYCLES(WDOG_CYCLES), .FILT_DEF_CYCLES(FILT_DEF_CYCLES))
    u_mfio_top_sva (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .field_in(field_in), .adc_ch7(adc_ch7), .adc_ch8(adc_ch8), .adc_valid(adc_valid),
    .field_out(field_out), .in_led(in_led), .wdog_err(wdog_err), .irq(irq));

// ==== verif/mfio_field_model.sv ====
/* mfio_field_model: sensors and analog source on the process side.
   assumes: levels commanded by the bench; converter runs on core_clk. */
`timescale 1ns/1ps
module mfio_field_model (
    input wire logic core_clk,
    input wire logic [7:0] lvl,
    output logic [7:0] field_in,
    output logic [11:0] adc_ch7,
    output logic [11:0] adc_ch8,
    output logic adc_valid
);
    logic [7:0] pin_r = 8'h00;
    logic [3:0] tick_r = 4'h0;
    // contacts switch one cycle after command; converter strobes every 16 cycles
    always @(posedge core_clk) begin
        pin_r <= lvl;
        tick_r <= tick_r + 4'h1;
    end
    assign field_in = pin_r;
    assign adc_valid = (tick_r == 4'hf);
    assign adc_ch7 = 12'ha5c;
    assign adc_ch8 = 12'h3f1;
endmodule : mfio_field_model

// ==== verif/multifunction_io_slots_tb.sv ====
/* multifunction_io_slots_tb: self-checking bench of mfio_top.
   assumes: short watchdog and filter parameters; field model on the pins. */
`timescale 1ns/1ps
module multifunction_io_slots_tb;
    typedef struct packed {logic [7:0] ctrl; logic [3:0] out; logic [31:0] duty;
        logic [3:0] exp;} mfio_row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] lvl = 8'h00;
    logic [31:0] reg_rdata;
    logic [7:0] field_in;
    logic [11:0] adc_ch7;
    logic [11:0] adc_ch8;
    logic adc_valid;
    logic [3:0] field_out;
    logic [7:0] in_led;
    logic wdog_err;
    logic irq;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    mfio_row_t rows [5];
    mfio_top #(.WDOG_CYCLES(200), .FILT_DEF_CYCLES(8)) u_mfio_top (.core_clk(core_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .field_in(field_in), .adc_ch7(adc_ch7),
        .adc_ch8(adc_ch8), .adc_valid(adc_valid), .field_out(field_out), .in_led(in_led),
        .wdog_err(wdog_err), .irq(irq));
    mfio_field_model u_mfio_field_model (.core_clk(core_clk), .lvl(lvl),
        .field_in(field_in), .adc_ch7(adc_ch7), .adc_ch8(adc_ch8), .adc_valid(adc_valid));
    // 50 MHz clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    // one gap cycle after each strobe so a strobe is never set twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
        @(posedge core_clk);
    endtask : rdc
    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            results();
        end
    end
    initial begin
        rows[0] = {8'h05, 4'hf, 32'h0000_0000, 4'hf};
        rows[1] = {8'h05, 4'h5, 32'h0000_0000, 4'h5};
        rows[2] = {8'h09, 4'h3, 32'hffff_ffff, 4'hf};
        rows[3] = {8'h09, 4'hc, 32'h0000_0000, 4'h0};
        rows[4] = {8'h09, 4'h0, 32'h0000_ffff, 4'h4};
        cyc(3);
        rst_n <= 1'b1;
        cyc(3);
        rdc(mfio_pkg::REG_CTRL, 32'h0000_0000);
        rdc(mfio_pkg::REG_FILT, 32'h0000_0008);
        rdc(mfio_pkg::REG_PWM_PER, 32'h0000_ffff);
        rdc(8'h3c, 32'h0000_0000);
        // slot modes against outputs; frequent writes keep supervision alive
        for (int i = 0; i < 5; i++) begin
            wr(mfio_pkg::REG_CTRL, {24'h0000_00, rows[i].ctrl});
            wr(mfio_pkg::REG_OUT, {28'h0000_000, rows[i].out});
            wr(mfio_pkg::REG_PWM_DUTY, rows[i].duty);
            cyc(4);
            check({28'h0000_000, field_out}, {28'h0000_000, rows[i].exp});
        end
        // inputs 1 and 8 ignore a long configured filter; glitch rejected
        wr(mfio_pkg::REG_CTRL, 32'h0000_0025);
        wr(mfio_pkg::REG_FILT, 32'h0000_0000);
        lvl <= 8'h81;
        cyc(5);
        check({24'h0000_00, in_led}, 32'h0000_0000);
        cyc(15);
        check({24'h0000_00, in_led}, 32'h0000_0081);
        lvl <= 8'h00;
        cyc(4);
        lvl <= 8'h81;
        cyc(30);
        check({24'h0000_00, in_led}, 32'h0000_0081);
        // input 3 on the clamped minimum filter
        lvl <= 8'h85;
        cyc(400);
        check({24'h0000_00, in_led}, 32'h0000_0081);
        cyc(200);
        check({24'h0000_00, in_led}, 32'h0000_0085);
        wr(mfio_pkg::REG_CTRL, 32'h0000_0045);
        cyc(40);
        rdc(mfio_pkg::REG_ANALOG, 32'h03f1_0a5c);
        // counter: five up, two down, threshold drives output 1
        lvl <= 8'h02;
        wr(mfio_pkg::REG_CTRL, 32'h0000_0002);
        wr(mfio_pkg::REG_THR_ON, 32'h0000_0004);
        wr(mfio_pkg::REG_THR_OFF, 32'h0000_0006);
        wr(mfio_pkg::REG_COUNT, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            lvl <= (i < 5) ? 8'h03 : 8'h01;
            cyc(4);
            lvl <= (i < 4) ? 8'h02 : 8'h00;
            cyc(4);
        end
        rdc(mfio_pkg::REG_COUNT, 32'h0000_0003);
        check({31'h0000_0000, field_out[0]}, 32'h0000_0001);
        // encoder: one quadrature cycle up, then input 3 latches
        wr(mfio_pkg::REG_CTRL, 32'h0000_0003);
        wr(mfio_pkg::REG_COUNT, 32'h0000_0000);
        lvl <= 8'h02;
        cyc(3);
        lvl <= 8'h03;
        cyc(3);
        lvl <= 8'h01;
        cyc(3);
        lvl <= 8'h00;
        // long low so filtered input 3 falls before its rising edge is needed
        cyc(440);
        lvl <= 8'h04;
        cyc(560);
        rdc(mfio_pkg::REG_LATCH, 32'h0000_0004);
        rdc(mfio_pkg::REG_COUNT, 32'h0000_0004);
        // input 3 in zero mode clears the counter instead of latching
        wr(mfio_pkg::REG_CTRL, 32'h0000_0083);
        lvl <= 8'h00;
        cyc(520);
        lvl <= 8'h04;
        cyc(520);
        rdc(mfio_pkg::REG_COUNT, 32'h0000_0000);
        // watchdog expiry masked, then unmasked, then cleared
        wr(mfio_pkg::REG_IRQ_STAT, 32'h0000_000f);
        cyc(220);
        check({31'h0000_0000, wdog_err}, 32'h0000_0001);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        rdc(mfio_pkg::REG_STATUS, 32'h0000_0104);
        wr(mfio_pkg::REG_IRQ_MASK, 32'h0000_0001);
        check({30'h0000_0000, wdog_err, irq}, 32'h0000_0001);
        wr(mfio_pkg::REG_IRQ_STAT, 32'h0000_0001);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        results();
    end
endmodule : multifunction_io_slots_tb
